// >>> rtl/rms_regs.vh
`ifndef RMS_REGS_VH
`define RMS_REGS_VH
`define RMS_ADDR_SYNC    12'h100
`define RMS_ADDR_FD      12'h104
`define RMS_ADDR_CU      12'h105
`define RMS_ADDR_FU_LO   12'h106
`define RMS_ADDR_FU_HI   12'h107
`define RMS_ADDR_FL_LO   12'h108
`define RMS_ADDR_FL_HI   12'h109
`define RMS_ADDR_DCB_HI  12'h110
`define RMS_ADDR_PORT    12'h111
`define RMS_ADDR_MON     12'h112
`define RMS_ADDR_PER0    12'h113
`define RMS_ADDR_PER1    12'h114
`define RMS_ADDR_PER2    12'h115
`define RMS_ADDR_RA0     12'h116
`define RMS_ADDR_RA1     12'h117
`define RMS_ADDR_RA2     12'h118
`define RMS_ADDR_RB0     12'h119
`define RMS_ADDR_RB1     12'h11a
`define RMS_ADDR_RB2     12'h11b
`define RMS_SYNC_MASTER  0
`define RMS_SYNC_DIV     1
`define RMS_SYNC_ONCE    2
`define RMS_SYNC_MON     7
`define RMS_FD_EN        0
`define RMS_MON_EN       0
`define RMS_MON_MS       3
`define RMS_MON_CPLX     7
`define RMS_PORT_EN      0
`define RMS_RST_ZERO     8'h00
`define RMS_RST_PORT     8'h04
`define RMS_RST_PER0     8'h40
`define RMS_MODE_MAG     2'b00
`define RMS_MODE_PEAK    2'b01
`define RMS_DIV_2        2'b01
`define RMS_DIV_4        2'b10
`define RMS_DIV_8        2'b11
`endif

// >>> rtl/rms_regs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "rms_regs.vh"
module rms_regs_top #(
  parameter AW = 12,
  parameter DW = 10
) (
  input  wire          clock_i,
  input  wire          nrst_i,
  input  wire          wr_i,
  input  wire          rd_i,
  input  wire [AW-1:0] addr_i,
  input  wire [7:0]    wdata_i,
  output reg  [7:0]    rdata_o,
  input  wire          sync_i,
  input  wire [DW-1:0] mag_a_i,
  input  wire [DW-1:0] mag_b_i,
  input  wire [13:0]   dc_b_i,
  input  wire          interleave_i,
  input  wire          chan_a_off_i,
  input  wire          chan_b_off_i,
  output reg           mon_sync_o,
  output reg           div_sync_o,
  output reg  [2:0]    fd_mode_o,
  output reg  [2:0]    coarse_level_o,
  output reg  [1:0]    fd_out_o,
  output reg  [1:0]    fd_oe_n_o,
  output reg           monitor_port_clock_o,
  output reg           monitor_port_en_o
);
  reg [7:0]  sync_ctl;
  reg [3:0]  fd_ctl;
  reg [2:0]  cu_lvl;
  reg [12:0] fu_lvl;
  reg [12:0] fl_lvl;
  reg [7:0]  port_ctl;
  reg [7:0]  mon_ctl;
  reg [23:0] period;
  reg [19:0] res_a;
  reg [19:0] res_b;
  reg [1:0]  sync_meta;
  reg [1:0]  sync_sync;
  reg        fine_upper_flag_a;
  reg        fine_upper_flag_b;
  reg        fine_lower_flag_a;
  reg        fine_lower_flag_b;
  reg [23:0] per_cnt;
  reg [19:0] acc_a;
  reg [19:0] acc_b;
  reg [2:0]  div_cnt;
  wire       sync_pulse;
  wire       master;
  wire [19:0] sq_a;
  wire [19:0] sq_b;
  wire [20:0] cplx;
  wire        period_end;
  reg  [19:0] samp_a;
  reg  [19:0] samp_b;
  reg  [2:0]  div_lim;
  reg  [1:0]  next_fd_out;
  reg  [1:0]  next_oe_n;

  // Unsigned 20-bit max helper
  function [19:0] rms_max;
    input [19:0] x;
    input [19:0] y;
    begin
      rms_max = (x > y) ? x : y;
    end
  endfunction

  // External sync pin through three flops, then edge detect
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_meta <= 2'b00;
      sync_sync <= 2'b00;
    end
    else
    begin
      sync_meta <= {sync_meta[0], sync_i};
      sync_sync <= {sync_sync[0], sync_meta[1]};
    end
  end
  assign sync_pulse = sync_sync[0] & ~sync_sync[1];
  assign master     = sync_ctl[`RMS_SYNC_MASTER];

  // Register writes; one-shot clear of divider enable
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_ctl <= `RMS_RST_ZERO;
      fd_ctl   <= 4'h0;
      cu_lvl   <= 3'h0;
      fu_lvl   <= 13'h0000;
      fl_lvl   <= 13'h0000;
      port_ctl <= `RMS_RST_PORT;
      mon_ctl  <= `RMS_RST_ZERO;
      period   <= {16'h0000, `RMS_RST_PER0};
    end
    else
    begin
      if (wr_i)
      begin
        case (addr_i)
          `RMS_ADDR_SYNC:  sync_ctl <= wdata_i & 8'h87;
          `RMS_ADDR_FD:    fd_ctl <= wdata_i[3:0];
          `RMS_ADDR_CU:    cu_lvl <= wdata_i[2:0];
          `RMS_ADDR_FU_LO: fu_lvl[7:0] <= wdata_i;
          `RMS_ADDR_FU_HI: fu_lvl[12:8] <= wdata_i[4:0];
          `RMS_ADDR_FL_LO: fl_lvl[7:0] <= wdata_i;
          `RMS_ADDR_FL_HI: fl_lvl[12:8] <= wdata_i[4:0];
          `RMS_ADDR_PORT:  port_ctl <= wdata_i & 8'h7f;
          `RMS_ADDR_MON:   mon_ctl <= wdata_i & 8'h8f;
          `RMS_ADDR_PER0:  period[7:0] <= wdata_i;
          `RMS_ADDR_PER1:  period[15:8] <= wdata_i;
          `RMS_ADDR_PER2:  period[23:16] <= wdata_i;
          default:         sync_ctl <= sync_ctl;
        endcase
      end
      // Hardware clear wins over a same-cycle write
      if (sync_pulse && master && sync_ctl[`RMS_SYNC_DIV] && sync_ctl[`RMS_SYNC_ONCE])
        sync_ctl[`RMS_SYNC_DIV] <= 1'b0;
    end
  end

  // Gated sync outputs, one-cycle pulses
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mon_sync_o <= 1'b0;
      div_sync_o <= 1'b0;
    end
    else
    begin
      mon_sync_o <= sync_pulse & master & sync_ctl[`RMS_SYNC_MON];
      div_sync_o <= sync_pulse & master & sync_ctl[`RMS_SYNC_DIV];
    end
  end

  // Fine threshold flags per channel
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fine_upper_flag_a <= 1'b0;
      fine_upper_flag_b <= 1'b0;
      fine_lower_flag_a <= 1'b0;
      fine_lower_flag_b <= 1'b0;
    end
    else
    begin
      fine_upper_flag_a <= {3'b000, mag_a_i} > fu_lvl;
      fine_upper_flag_b <= {3'b000, mag_b_i} > fu_lvl;
      fine_lower_flag_a <= {3'b000, mag_a_i} < fl_lvl;
      fine_lower_flag_b <= {3'b000, mag_b_i} < fl_lvl;
    end
  end

  // Fast-detect pin data by mode; simple mapping of flags
  always @*
  begin
    case (fd_ctl[3:1])
      3'd0:    next_fd_out = {fine_upper_flag_b, fine_upper_flag_a};
      3'd1:    next_fd_out = {fine_lower_flag_b, fine_lower_flag_a};
      3'd2:    next_fd_out = {fine_upper_flag_a, fine_lower_flag_a};
      3'd3:    next_fd_out = {fine_upper_flag_b, fine_lower_flag_b};
      default: next_fd_out = {fine_upper_flag_b | fine_lower_flag_b, fine_upper_flag_a | fine_lower_flag_a};
    endcase
    next_oe_n = 2'b00;
    if (!fd_ctl[`RMS_FD_EN])
      next_oe_n = 2'b11;
    else if (interleave_i)
    begin
      if (chan_a_off_i && chan_b_off_i)
        next_oe_n = 2'b11;
      else if (chan_a_off_i)
        next_fd_out = {2{next_fd_out[1]}};
      else if (chan_b_off_i)
        next_fd_out = {2{next_fd_out[0]}};
    end
  end

  // Fast-detect pins registered
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fd_out_o       <= 2'b00;
      fd_oe_n_o      <= 2'b11;
      fd_mode_o      <= 3'b000;
      coarse_level_o <= 3'b000;
    end
    else
    begin
      fd_out_o       <= next_fd_out;
      fd_oe_n_o      <= next_oe_n;
      fd_mode_o      <= fd_ctl[3:1];
      coarse_level_o <= cu_lvl;
    end
  end

  // Per-sample measure: power (ms) or peak; threshold count
  assign sq_a = {10'h000, mag_a_i} * {10'h000, mag_a_i};
  assign sq_b = {10'h000, mag_b_i} * {10'h000, mag_b_i};
  assign cplx = {1'b0, sq_a} + {1'b0, sq_b};
  always @*
  begin
    case (mon_ctl[2:1])
      `RMS_MODE_MAG:
      begin
        // Power select: squares for ms, plain magnitude stands in for rms
        samp_a = mon_ctl[`RMS_MON_MS] ? sq_a : {10'h000, mag_a_i};
        samp_b = mon_ctl[`RMS_MON_MS] ? sq_b : {10'h000, mag_b_i};
        if (mon_ctl[`RMS_MON_CPLX])
        begin
          samp_a = cplx[20:1];
          samp_b = cplx[20:1];
        end
      end
      `RMS_MODE_PEAK:
      begin
        samp_a = {10'h000, mag_a_i};
        samp_b = {10'h000, mag_b_i};
      end
      default:
      begin
        samp_a = {19'h00000, fine_upper_flag_a};
        samp_b = {19'h00000, fine_upper_flag_b};
      end
    endcase
  end

  // Period counter and accumulators; atomic result latch
  assign period_end = (per_cnt + 24'h00_0001) >= period;
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      per_cnt <= 24'h00_0000;
      acc_a   <= 20'h0_0000;
      acc_b   <= 20'h0_0000;
      res_a   <= 20'h0_0000;
      res_b   <= 20'h0_0000;
    end
    else if (!mon_ctl[`RMS_MON_EN] || mon_sync_o)
    begin
      per_cnt <= 24'h00_0000;
      acc_a   <= 20'h0_0000;
      acc_b   <= 20'h0_0000;
    end
    else if (period_end)
    begin
      per_cnt <= 24'h00_0000;
      acc_a   <= 20'h0_0000;
      acc_b   <= 20'h0_0000;
      res_a   <= rms_max(acc_a, samp_a);
      res_b   <= rms_max(acc_b, samp_b);
    end
    else
    begin
      per_cnt <= per_cnt + 24'h00_0001;
      if (mon_ctl[2:1] == `RMS_MODE_PEAK || mon_ctl[2:1] == `RMS_MODE_MAG)
      begin
        // Magnitude and peak modes keep a running peak of the sample
        acc_a <= rms_max(acc_a, samp_a);
        acc_b <= rms_max(acc_b, samp_b);
      end
      else
      begin
        acc_a <= acc_a + samp_a;
        acc_b <= acc_b + samp_b;
      end
    end
  end

  // Port clock divider: divide by 2, 4 or 8
  always @*
  begin
    case (port_ctl[3:2])
      `RMS_DIV_4: div_lim = 3'd1;
      `RMS_DIV_8: div_lim = 3'd3;
      default:    div_lim = 3'd0;
    endcase
  end
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_cnt              <= 3'd0;
      monitor_port_clock_o <= 1'b0;
      monitor_port_en_o    <= 1'b0;
    end
    else
    begin
      monitor_port_en_o <= port_ctl[`RMS_PORT_EN] & mon_ctl[`RMS_MON_EN];
      if (div_cnt >= div_lim)
      begin
        div_cnt              <= 3'd0;
        monitor_port_clock_o <= ~monitor_port_clock_o;
      end
      else
        div_cnt <= div_cnt + 3'd1;
    end
  end

  // Register read-back, one cycle latency
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `RMS_ADDR_SYNC:   rdata_o <= sync_ctl;
        `RMS_ADDR_FD:     rdata_o <= {4'h0, fd_ctl};
        `RMS_ADDR_CU:     rdata_o <= {5'h00, cu_lvl};
        `RMS_ADDR_FU_LO:  rdata_o <= fu_lvl[7:0];
        `RMS_ADDR_FU_HI:  rdata_o <= {3'b000, fu_lvl[12:8]};
        `RMS_ADDR_FL_LO:  rdata_o <= fl_lvl[7:0];
        `RMS_ADDR_FL_HI:  rdata_o <= {3'b000, fl_lvl[12:8]};
        `RMS_ADDR_DCB_HI: rdata_o <= {2'b00, dc_b_i[13:8]};
        `RMS_ADDR_PORT:   rdata_o <= port_ctl;
        `RMS_ADDR_MON:    rdata_o <= mon_ctl;
        `RMS_ADDR_PER0:   rdata_o <= period[7:0];
        `RMS_ADDR_PER1:   rdata_o <= period[15:8];
        `RMS_ADDR_PER2:   rdata_o <= period[23:16];
        `RMS_ADDR_RA0:    rdata_o <= res_a[7:0];
        `RMS_ADDR_RA1:    rdata_o <= res_a[15:8];
        `RMS_ADDR_RA2:    rdata_o <= {4'h0, res_a[19:16]};
        `RMS_ADDR_RB0:    rdata_o <= res_b[7:0];
        `RMS_ADDR_RB1:    rdata_o <= res_b[15:8];
        `RMS_ADDR_RB2:    rdata_o <= {4'h0, res_b[19:16]};
        default:          rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // rms_regs_top
`default_nettype wire

// >>> tb/rms_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rms_host_model (
  input  wire logic        clock_i,
  input  wire logic [7:0]  rdata_i,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [11:0] addr_o,
  output var  logic [7:0]  wdata_o
);
  // Strobes idle low
  initial
  begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 12'h000;
    wdata_o = 8'h00;
  end
  // One-cycle write; data scrambled once taken
  task automatic write(input logic [11:0] a, input logic [7:0] d);
  begin
    @(posedge clock_i);
    #1 addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clock_i);
    #1 wr_o = 1'b0;
    wdata_o = ~d;
  end
  endtask
  // Read data is registered at the strobe's edge
  task automatic read(input logic [11:0] a, output logic [7:0] d);
  begin
    @(posedge clock_i);
    #1 addr_o = a;
    rd_o = 1'b1;
    @(posedge clock_i);
    #1 rd_o = 1'b0;
    d = rdata_i;
  end
  endtask
  // Period is never set short enough to spoil results
  task automatic program_period(input logic [23:0] p);
  begin
    if (p < 24'h00_0080)
      p = 24'h00_0080;
    write(12'h113, p[7:0]);
    write(12'h114, p[15:8]);
    write(12'h115, p[23:16]);
  end
  endtask
endmodule // rms_host_model
`default_nettype wire

// >>> tb/rms_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rms_regs_asserts (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        wr_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        sync_i,
  input wire logic        interleave_i,
  input wire logic        chan_a_off_i,
  input wire logic        chan_b_off_i,
  input wire logic        mon_sync_o,
  input wire logic        div_sync_o,
  input wire logic [2:0]  fd_mode_o,
  input wire logic [2:0]  coarse_level_o,
  input wire logic [1:0]  fd_oe_n_o
);
  logic [7:0] sq;
  logic       fd_en;
  logic [1:0] age;
  logic       once;
  wire        sync_wr = wr_i && addr_i == 12'h100;
  wire        fd_on = fd_en && interleave_i && age == 2'h3;
  // Shadow of host settings; age counts quiet cycles after any write
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sq    <= 8'h00;
      fd_en <= 1'b0;
      age   <= 2'h0;
      once  <= 1'b0;
    end
    else
    begin
      if (sync_wr)
        sq <= wdata_i;
      if (wr_i && addr_i == 12'h104)
        fd_en <= wdata_i[0];
      age  <= wr_i ? 2'h0 : age + {1'b0, age != 2'h3};
      once <= !sync_wr && (once || (div_sync_o && sq[2]));
    end
  end
  default clocking dcb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Field copies show two edges after their write
  chk_fd_mode_copy: assert property (
    (wr_i && addr_i == 12'h104) ##1 !wr_i |=> fd_mode_o == $past(wdata_i[3:1], 2))
    else $error("mode copy wrong");
  chk_coarse_copy: assert property (
    (wr_i && addr_i == 12'h105) ##1 !wr_i |=> coarse_level_o == $past(wdata_i[2:0], 2))
    else $error("coarse copy wrong");
  chk_fd_off_hiz: assert property (age == 2'h3 && !fd_en |-> fd_oe_n_o == 2'b11)
    else $error("pins driven while disabled");
  chk_both_off_hiz: assert property ((fd_on && chan_a_off_i && chan_b_off_i) [*3] |-> fd_oe_n_o == 2'b11)
    else $error("pins driven, both off");
  chk_one_off_drive: assert property ((fd_on && (chan_a_off_i ^ chan_b_off_i)) [*3] |-> fd_oe_n_o == 2'b00)
    else $error("pins idle, one active");
  chk_mon_gated: assert property (mon_sync_o |-> sq[7] && sq[0])
    else $error("monitor sync leaked");
  chk_mon_follow: assert property ($rose(sync_i) && age == 2'h3 && sq[7] && sq[0] |-> ##[2:6] mon_sync_o)
    else $error("monitor sync missing");
  chk_div_gated: assert property (div_sync_o |-> sq[1] && sq[0] && !once)
    else $error("divider sync leaked");
  cover property (mon_sync_o);
  cover property (div_sync_o && sq[2]);
  cover property (fd_on && chan_a_off_i && fd_oe_n_o == 2'b00);
endmodule // rms_regs_asserts
bind rms_regs_top rms_regs_asserts rms_regs_asserts_inst (.clock_i, .nrst_i, .wr_i, .addr_i, .wdata_i, .sync_i,
  .interleave_i, .chan_a_off_i, .chan_b_off_i, .mon_sync_o, .div_sync_o, .fd_mode_o, .coarse_level_o, .fd_oe_n_o);
`default_nettype wire

// >>> tb/test_rms_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module test_rms_regs_top;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        sync_i = 1'b0;
  logic        interleave_i = 1'b0;
  logic        chan_a_off_i = 1'b0;
  logic        chan_b_off_i = 1'b0;
  logic [9:0]  mag_a_i = 10'h155;
  logic [9:0]  mag_b_i = 10'h0aa;
  logic [13:0] dc_b_i = 14'h2d5a;
  wire         wr_i, rd_i, mon_sync_o, div_sync_o, monitor_port_clock_o, monitor_port_en_o;
  wire  [11:0] addr_i;
  wire  [7:0]  wdata_i, rdata_o;
  wire  [2:0]  fd_mode_o, coarse_level_o;
  wire  [1:0]  fd_out_o, fd_oe_n_o;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  rms_regs_top rms_regs_top_inst (.clock_i, .nrst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .sync_i,
    .mag_a_i, .mag_b_i, .dc_b_i, .interleave_i, .chan_a_off_i, .chan_b_off_i, .mon_sync_o, .div_sync_o,
    .fd_mode_o, .coarse_level_o, .fd_out_o, .fd_oe_n_o, .monitor_port_clock_o, .monitor_port_en_o);
  rms_host_model rms_host_model_inst (.clock_i, .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  // Clock and hang guard
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude;
  begin
    $display("compared %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Register access through the host model
  task automatic w(input logic [11:0] a, input logic [7:0] d);
  begin
    rms_host_model_inst.write(a, d);
  end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
  begin
    rms_host_model_inst.read(a, d);
    `CHK(d, e)
  end
  endtask
  task automatic wrchk(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
  begin
    w(a, d);
    rchk(a, e);
  end
  endtask
  // Reset values, reserved bits and read-only places
  task automatic t_fields;
  begin
    rchk(12'h111, 8'h04);
    rchk(12'h113, 8'h40);
    rchk(12'h115, 8'h00);
    rchk(12'h112, 8'h00);
    wrchk(12'h104, 8'hff, 8'h0f);
    wrchk(12'h105, 8'hff, 8'h07);
    wrchk(12'h107, 8'hff, 8'h1f);
    wrchk(12'h109, 8'hff, 8'h1f);
    wrchk(12'h112, 8'hfe, 8'h8e);
    wrchk(12'h110, 8'hff, {2'b00, dc_b_i[13:8]});
    wrchk(12'h118, 8'hff, 8'h00);
    wrchk(12'h11c, 8'hff, 8'h00);
    w(12'h112, 8'h00);
  end
  endtask
  // Raise the sync pin and count gated pulses
  task automatic pulse(input logic [3:0] em, input logic [3:0] ed);
    logic [3:0] nm;
    logic [3:0] nd;
  begin
    nm = 4'h0;
    nd = 4'h0;
    repeat (3) @(posedge clock_i);
    #1 sync_i = 1'b1;
    repeat (10)
    begin
      @(negedge clock_i);
      nm = nm + {3'h0, mon_sync_o};
      nd = nd + {3'h0, div_sync_o};
    end
    @(posedge clock_i);
    #1 sync_i = 1'b0;
    `CHK(nm, em)
    `CHK(nd, ed)
  end
  endtask
  task automatic t_sync;
  begin
    w(12'h100, 8'h81);
    pulse(4'h1, 4'h0);
    w(12'h100, 8'h03);
    pulse(4'h0, 4'h1);
    w(12'h100, 8'h86);
    pulse(4'h0, 4'h0);
    w(12'h100, 8'h07);
    pulse(4'h0, 4'h1);
    pulse(4'h0, 4'h0);
    rchk(12'h100, 8'h05);
  end
  endtask
  task automatic oe_chk(input logic [1:0] e, input logic [1:0] eo);
  begin
    repeat (4) @(posedge clock_i);
    #1 `CHK(fd_oe_n_o, e)
    `CHK(fd_out_o, eo)
  end
  endtask
  // Fast-detect pin enables and data across channel states
  task automatic t_fd;
  begin
    w(12'h108, 8'h00);
    w(12'h109, 8'h01);
    w(12'h104, 8'h0e);
    oe_chk(2'b11, 2'b10);
    `CHK(fd_mode_o, 3'b111)
    w(12'h104, 8'h03);
    oe_chk(2'b00, 2'b10);
    interleave_i = 1'b1;
    chan_a_off_i = 1'b1;
    oe_chk(2'b00, 2'b11);
    chan_b_off_i = 1'b1;
    oe_chk(2'b11, 2'b10);
    chan_a_off_i = 1'b0;
    oe_chk(2'b00, 2'b00);
    w(12'h105, 8'h05);
    oe_chk(2'b00, 2'b00);
    `CHK(coarse_level_o, 3'b101)
    interleave_i = 1'b0;
    chan_b_off_i = 1'b0;
    w(12'h106, 8'h00);
    w(12'h107, 8'h01);
    w(12'h104, 8'h01);
    oe_chk(2'b00, 2'b01);
  end
  endtask
  // Peak results and the port clock divider
  task automatic t_monitor;
    logic [4:0] k;
    logic       last;
  begin
    rms_host_model_inst.program_period(24'h00_0080);
    rchk(12'h113, 8'h80);
    w(12'h112, 8'h03);
    repeat (300) @(posedge clock_i);
    rchk(12'h116, 8'h55);
    rchk(12'h117, 8'h01);
    rchk(12'h118, 8'h00);
    rchk(12'h119, 8'haa);
    rchk(12'h11b, 8'h00);
    w(12'h112, 8'h09);
    repeat (300) @(posedge clock_i);
    rchk(12'h116, 8'h39);
    rchk(12'h117, 8'hc6);
    rchk(12'h118, 8'h01);
    rchk(12'h11a, 8'h70);
    w(12'h112, 8'h01);
    repeat (300) @(posedge clock_i);
    rchk(12'h116, 8'h55);
    rchk(12'h11a, 8'h00);
    `CHK(monitor_port_en_o, 1'b0)
    for (int c = 1; c < 4; c++)
    begin
      w(12'h111, {4'h0, c[1:0], 2'b01});
      repeat (8) @(posedge clock_i);
      `CHK(monitor_port_en_o, 1'b1)
      k = 5'h00;
      last = monitor_port_clock_o;
      repeat (16)
      begin
        @(negedge clock_i);
        k = k + {4'h0, monitor_port_clock_o !== last};
        last = monitor_port_clock_o;
      end
      `CHK(k, 5'h10 >> (c - 1))
    end
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    t_fields();
    t_sync();
    t_fd();
    t_monitor();
    conclude();
  end
endmodule // test_rms_regs_top
`default_nettype wire
